// *** src/ubgdr_top.sv ***
`timescale 1ns/1ps
module ubgdr_top (
    input  wire logic                mclk_i,
    input  wire logic                arst_n_i,
    input  wire logic [7:0]          addr_i,
    input  wire logic [7:0]          wdata_i,
    input  wire logic                wr_i,
    input  wire logic                rd_i,
    output logic      [7:0]          rdata_o,
    input  wire logic                tx_shift_empty_i,
    output logic      [7:0]          tx_data_o,
    output logic                     tx_load_o,
    input  wire logic                tx_done_i,
    input  wire logic                rx_valid_i,
    input  wire ubgdr_pkg::ubgdr_rx_t rx_word_i,
    input  wire logic                rx_idle_i,
    output logic                     tx_rate_tick_o,
    output logic                     rx_rate_tick_o,
    output logic                     irq_o
);

    // ------------------------------------------------------------
    // register decode
    // ------------------------------------------------------------
    logic [7:0]            status_reg;
    logic [7:0]            baud_reg;
    logic [7:0]            ctrl1_reg;
    logic [7:0]            ctrl2_reg;
    logic [7:0]            erx_reg;
    logic [7:0]            etx_reg;
    logic [7:0]            thr_reg;
    logic [7:0]            rhr_reg;
    logic [7:0]            rdata_reg;
    logic [ubgdr_pkg::EV_W-1:0] evt_reg;
    logic [ubgdr_pkg::EV_W-1:0] evt_next;
    logic [ubgdr_pkg::EV_W-1:0] mask_reg;
    logic                  irq_reg;
    logic                  tx_load_reg;
    logic [7:0]            tx_data_reg;
    logic                  idle_arm_reg;
    ubgdr_pkg::ubgdr_seq_t seq_reg;

    logic status_acc;
    logic char_wr;
    logic char_rd;
    logic rx_clr;
    logic tc_clr;
    logic rx_take;
    logic rx_over;
    logic idle_set;
    logic tx_load_next;

    assign status_acc = (rd_i || wr_i) && (addr_i == ubgdr_pkg::OFS_STATUS);
    assign char_wr    = wr_i && (addr_i == ubgdr_pkg::OFS_CHAR);
    assign char_rd    = rd_i && (addr_i == ubgdr_pkg::OFS_CHAR);
    assign rx_clr     = char_rd && (seq_reg == ubgdr_pkg::SEQ_ARMED);
    assign tc_clr     = char_wr && (seq_reg == ubgdr_pkg::SEQ_ARMED);
    // a byte arriving while software drains the old one is not an overrun
    assign rx_take    = rx_valid_i && (!status_reg[ubgdr_pkg::ST_RDRF] || rx_clr);
    assign rx_over    = rx_valid_i && !rx_take;
    assign idle_set   = rx_idle_i && idle_arm_reg;
    assign tx_load_next = !status_reg[ubgdr_pkg::ST_TDRE] && tx_shift_empty_i && !tx_load_reg;

    // ------------------------------------------------------------
    // clear sequence tracker
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            seq_reg <= ubgdr_pkg::SEQ_IDLE;
        end else if (status_acc) begin
            seq_reg <= ubgdr_pkg::SEQ_ARMED;
        end else if (char_wr || char_rd) begin
            seq_reg <= ubgdr_pkg::SEQ_IDLE;
        end
    end

    // ------------------------------------------------------------
    // software registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            baud_reg  <= ubgdr_pkg::RST_BAUD;
            ctrl1_reg <= ubgdr_pkg::RST_CTRL;
            ctrl2_reg <= ubgdr_pkg::RST_CTRL;
            erx_reg   <= ubgdr_pkg::RST_EXT;
            etx_reg   <= ubgdr_pkg::RST_EXT;
            mask_reg  <= '0;
        end else if (wr_i) begin
            case (addr_i)
                ubgdr_pkg::OFS_BAUD:  baud_reg  <= wdata_i;
                ubgdr_pkg::OFS_CTRL1: ctrl1_reg <= wdata_i;
                ubgdr_pkg::OFS_CTRL2: ctrl2_reg <= wdata_i;
                ubgdr_pkg::OFS_ERX:   erx_reg   <= wdata_i;
                ubgdr_pkg::OFS_ETX:   etx_reg   <= wdata_i;
                ubgdr_pkg::OFS_MASK:  mask_reg  <= wdata_i[ubgdr_pkg::EV_W-1:0];
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rdata_reg <= ubgdr_pkg::RST_ZERO;
        end else if (rd_i) begin
            case (addr_i)
                ubgdr_pkg::OFS_STATUS: rdata_reg <= status_reg;
                ubgdr_pkg::OFS_CHAR:   rdata_reg <= rhr_reg;
                ubgdr_pkg::OFS_BAUD:   rdata_reg <= baud_reg;
                ubgdr_pkg::OFS_CTRL1:  rdata_reg <= ctrl1_reg;
                ubgdr_pkg::OFS_CTRL2:  rdata_reg <= ctrl2_reg;
                ubgdr_pkg::OFS_ERX:    rdata_reg <= erx_reg;
                ubgdr_pkg::OFS_ETX:    rdata_reg <= etx_reg;
                ubgdr_pkg::OFS_EVT:    rdata_reg <= 8'(evt_reg);
                ubgdr_pkg::OFS_MASK:   rdata_reg <= 8'(mask_reg);
                default:               rdata_reg <= ubgdr_pkg::RST_ZERO;
            endcase
        end
    end
    assign rdata_o = rdata_reg;

    // ------------------------------------------------------------
    // transmit path
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            thr_reg     <= ubgdr_pkg::RST_ZERO;
            tx_data_reg <= ubgdr_pkg::RST_ZERO;
            tx_load_reg <= 1'b0;
        end else begin
            if (char_wr) begin
                thr_reg <= wdata_i;
            end
            tx_load_reg <= tx_load_next;
            if (tx_load_next) begin
                tx_data_reg <= thr_reg;
            end
        end
    end
    assign tx_data_o = tx_data_reg;
    assign tx_load_o = tx_load_reg;

    // ------------------------------------------------------------
    // receive holding register
    // ------------------------------------------------------------
    // on overrun the held byte is kept and the shift register is lost
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rhr_reg <= ubgdr_pkg::RST_ZERO;
        end else if (rx_take) begin
            rhr_reg <= rx_word_i.data;
        end
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            idle_arm_reg <= 1'b0;
        end else if (rx_take) begin
            idle_arm_reg <= 1'b1;
        end else if (idle_set) begin
            idle_arm_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // status flags, hardware set wins over the clear sequence; for TDRE a character write wins over the set
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            status_reg <= ubgdr_pkg::RST_STATUS;
        end else begin
            if (char_wr) begin
                status_reg[ubgdr_pkg::ST_TDRE] <= 1'b0;
            end else if (tx_load_reg) begin
                status_reg[ubgdr_pkg::ST_TDRE] <= 1'b1;
            end
            if (tx_done_i) begin
                status_reg[ubgdr_pkg::ST_TC] <= 1'b1;
            end else if (tc_clr) begin
                status_reg[ubgdr_pkg::ST_TC] <= 1'b0;
            end
            if (rx_take) begin
                status_reg[ubgdr_pkg::ST_RDRF] <= 1'b1;
                status_reg[ubgdr_pkg::ST_NF]   <= rx_word_i.noise;
                status_reg[ubgdr_pkg::ST_FE]   <= rx_word_i.framing;
                status_reg[ubgdr_pkg::ST_PE]   <= rx_word_i.parity;
            end else if (rx_clr) begin
                status_reg[ubgdr_pkg::ST_RDRF] <= 1'b0;
                status_reg[ubgdr_pkg::ST_NF]   <= 1'b0;
                status_reg[ubgdr_pkg::ST_FE]   <= 1'b0;
                status_reg[ubgdr_pkg::ST_PE]   <= 1'b0;
            end
            if (rx_over) begin
                status_reg[ubgdr_pkg::ST_OVR] <= 1'b1;
            end else if (rx_clr) begin
                status_reg[ubgdr_pkg::ST_OVR] <= 1'b0;
            end
            if (idle_set) begin
                status_reg[ubgdr_pkg::ST_IDLE] <= 1'b1;
            end else if (rx_clr) begin
                status_reg[ubgdr_pkg::ST_IDLE] <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // interrupt events, cleared by reading them
    // ------------------------------------------------------------
    always_comb begin
        evt_next = evt_reg;
        if (rd_i && (addr_i == ubgdr_pkg::OFS_EVT)) begin
            evt_next = '0;
        end
        evt_next[ubgdr_pkg::EV_TXE]  = evt_next[ubgdr_pkg::EV_TXE] | tx_load_reg;
        evt_next[ubgdr_pkg::EV_TC]   = evt_next[ubgdr_pkg::EV_TC] | tx_done_i;
        evt_next[ubgdr_pkg::EV_RXF]  = evt_next[ubgdr_pkg::EV_RXF] | rx_take;
        evt_next[ubgdr_pkg::EV_OVR]  = evt_next[ubgdr_pkg::EV_OVR] | rx_over;
        evt_next[ubgdr_pkg::EV_IDLE] = evt_next[ubgdr_pkg::EV_IDLE] | idle_set;
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            evt_reg <= '0;
            irq_reg <= 1'b0;
        end else begin
            evt_reg <= evt_next;
            irq_reg <= |(evt_next & mask_reg);
        end
    end
    assign irq_o = irq_reg;

    // ------------------------------------------------------------
    // shared prescaler and divide-by-16 stage
    // ------------------------------------------------------------
    logic [3:0] pre_cnt_reg;
    logic [3:0] pre_last;
    logic [3:0] d16_cnt_reg;
    logic       run;
    logic       pre_tick;
    logic       d16_tick;

    // stop bit freezes every counter to save power
    assign run = !ctrl1_reg[ubgdr_pkg::CTRL1_STOP];

    always_comb begin
        case (baud_reg[ubgdr_pkg::BAUD_PRE_HI:ubgdr_pkg::BAUD_PRE_LO])
            ubgdr_pkg::PRE_CODE_1: pre_last = ubgdr_pkg::PRE_LAST_1;
            ubgdr_pkg::PRE_CODE_3: pre_last = ubgdr_pkg::PRE_LAST_3;
            ubgdr_pkg::PRE_CODE_4: pre_last = ubgdr_pkg::PRE_LAST_4;
            default:               pre_last = ubgdr_pkg::PRE_LAST_13;
        endcase
    end

    assign pre_tick = run && (pre_cnt_reg >= pre_last);
    assign d16_tick = run && (d16_cnt_reg == ubgdr_pkg::DIV16_LAST);

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pre_cnt_reg <= '0;
        end else if (pre_tick) begin
            pre_cnt_reg <= '0;
        end else if (run) begin
            pre_cnt_reg <= pre_cnt_reg + 4'h1;
        end
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            d16_cnt_reg <= '0;
        end else if (run) begin
            d16_cnt_reg <= d16_cnt_reg + 4'h1;
        end
    end

    // ------------------------------------------------------------
    // per-direction rate generators: index 0 transmit, 1 receive
    // ------------------------------------------------------------
    logic [1:0] rate_tick;
    logic [2:0] div_code [2];
    logic [7:0] ext_val  [2];

    assign div_code[0] = baud_reg[ubgdr_pkg::BAUD_TXD_HI:ubgdr_pkg::BAUD_TXD_LO];
    assign div_code[1] = baud_reg[ubgdr_pkg::BAUD_RXD_HI:ubgdr_pkg::BAUD_RXD_LO];
    assign ext_val[0]  = etx_reg;
    assign ext_val[1]  = erx_reg;

    for (genvar g = 0; g < 2; g++) begin : g_rate
        logic [6:0] div_cnt_reg;
        logic [6:0] div_last;
        logic [7:0] ext_cnt_reg;
        logic       conv_tick;
        logic       ext_tick;
        logic       tick_reg;

        assign div_last  = 7'((ubgdr_pkg::DIV_ONE << div_code[g]) - ubgdr_pkg::DIV_ONE);
        assign conv_tick = pre_tick && (div_cnt_reg >= div_last);
        assign ext_tick  = d16_tick && (ext_cnt_reg >= ext_val[g] - ubgdr_pkg::DIV_ONE);

        always_ff @(posedge mclk_i or negedge arst_n_i) begin
            if (!arst_n_i) begin
                div_cnt_reg <= '0;
            end else if (conv_tick) begin
                div_cnt_reg <= '0;
            end else if (pre_tick) begin
                div_cnt_reg <= div_cnt_reg + 7'h01;
            end
        end

        always_ff @(posedge mclk_i or negedge arst_n_i) begin
            if (!arst_n_i) begin
                ext_cnt_reg <= '0;
            end else if (ext_tick) begin
                ext_cnt_reg <= '0;
            end else if (d16_tick) begin
                ext_cnt_reg <= ext_cnt_reg + ubgdr_pkg::DIV_ONE;
            end
        end

        always_ff @(posedge mclk_i or negedge arst_n_i) begin
            if (!arst_n_i) begin
                tick_reg <= 1'b0;
            end else if (ext_val[g] != ubgdr_pkg::RST_ZERO) begin
                tick_reg <= ext_tick;
            end else begin
                tick_reg <= conv_tick;
            end
        end
        assign rate_tick[g] = tick_reg;
    end

    assign tx_rate_tick_o = rate_tick[0];
    assign rx_rate_tick_o = rate_tick[1];

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    AST_CHAR_READ_RHR: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        char_rd |=> rdata_o == $past(rhr_reg))
        else $error("character read did not return receive byte");

    AST_CHAR_WRITE_THR: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        char_wr |=> thr_reg == $past(wdata_i) && (rhr_reg == $past(rhr_reg) || $past(rx_take)))
        else $error("character write disturbed the wrong holding register");

    AST_TX_HANDOFF: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        $rose(tx_load_o) |-> tx_data_o == $past(thr_reg) ##1 status_reg[ubgdr_pkg::ST_TDRE] || $past(char_wr))
        else $error("transmit byte not handed to shift register");

    AST_RX_LOAD: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        rx_valid_i && !status_reg[ubgdr_pkg::ST_RDRF] |=>
            rhr_reg == $past(rx_word_i.data) && status_reg[ubgdr_pkg::ST_RDRF])
        else $error("receive byte not loaded");

    // helper: cycles since the last prescaler tick, trusted only once a tick follows the last baud change
    logic [3:0] pre_gap_reg;
    logic       pre_ref_reg;
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pre_gap_reg <= '0;
            pre_ref_reg <= 1'b0;
        end else if (!run || (wr_i && addr_i == ubgdr_pkg::OFS_BAUD)) begin
            pre_gap_reg <= '0;
            pre_ref_reg <= 1'b0;
        end else if (pre_tick) begin
            pre_gap_reg <= '0;
            pre_ref_reg <= 1'b1;
        end else begin
            pre_gap_reg <= pre_gap_reg + 4'h1;
        end
    end

    AST_PRE_DIV13: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        pre_tick && pre_last == ubgdr_pkg::PRE_LAST_13 && pre_ref_reg |-> pre_gap_reg == ubgdr_pkg::PRE_LAST_13)
        else $error("prescaler period wrong for divide by 13");

    AST_PRE_NO_EARLY: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        pre_tick && pre_last == ubgdr_pkg::PRE_LAST_3 ##1 $stable(baud_reg) |-> !pre_tick)
        else $error("prescaler ticked early");

    AST_EXT_PRIORITY: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        erx_reg != ubgdr_pkg::RST_ZERO && !g_rate[1].ext_tick |=> !rx_rate_tick_o)
        else $error("receive tick without extended divider");

    AST_CONV_TX: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        etx_reg == ubgdr_pkg::RST_ZERO && g_rate[0].conv_tick |=> tx_rate_tick_o)
        else $error("transmit tick missing in conventional mode");

    AST_RX_CLEAR_SEQ: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        $fell(status_reg[ubgdr_pkg::ST_RDRF]) |-> $past(char_rd) && $past(seq_reg) == ubgdr_pkg::SEQ_ARMED)
        else $error("receive flag cleared without the sequence");

    AST_TC_CLEAR_SEQ: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        status_reg[ubgdr_pkg::ST_TC] && tc_clr && !tx_done_i |=> !status_reg[ubgdr_pkg::ST_TC])
        else $error("complete flag not cleared by sequence");

    AST_TC_HOLD: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        $fell(status_reg[ubgdr_pkg::ST_TC]) |-> $past(tc_clr))
        else $error("complete flag fell without sequence");

endmodule // ubgdr_top

// *** inc/ubgdr_pkg.sv ***
package ubgdr_pkg;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_STATUS = 8'h50;
    localparam logic [7:0] OFS_CHAR   = 8'h51;
    localparam logic [7:0] OFS_BAUD   = 8'h52;
    localparam logic [7:0] OFS_CTRL1  = 8'h53;
    localparam logic [7:0] OFS_CTRL2  = 8'h54;
    localparam logic [7:0] OFS_ERX    = 8'h55;
    localparam logic [7:0] OFS_ETX    = 8'h57;
    localparam logic [7:0] OFS_EVT    = 8'h58;
    localparam logic [7:0] OFS_MASK   = 8'h59;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_STATUS = 8'hc0;
    localparam logic [7:0] RST_BAUD   = 8'h00;
    localparam logic [7:0] RST_CTRL   = 8'h00;
    localparam logic [7:0] RST_EXT    = 8'h00;
    localparam logic [7:0] RST_ZERO   = 8'h00;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int ST_TDRE = 7;
    localparam int ST_TC   = 6;
    localparam int ST_RDRF = 5;
    localparam int ST_IDLE = 4;
    localparam int ST_OVR  = 3;
    localparam int ST_NF   = 2;
    localparam int ST_FE   = 1;
    localparam int ST_PE   = 0;
    localparam int BAUD_PRE_HI = 7;
    localparam int BAUD_PRE_LO = 6;
    localparam int BAUD_TXD_HI = 5;
    localparam int BAUD_TXD_LO = 3;
    localparam int BAUD_RXD_HI = 2;
    localparam int BAUD_RXD_LO = 0;
    localparam int CTRL1_STOP  = 5;
    localparam int EV_TXE  = 0;
    localparam int EV_TC   = 1;
    localparam int EV_RXF  = 2;
    localparam int EV_OVR  = 3;
    localparam int EV_IDLE = 4;
    localparam int EV_W    = 5;

    // ------------------------------------------------------------
    // baud generator constants
    // ------------------------------------------------------------
    localparam logic [1:0] PRE_CODE_1  = 2'h0;
    localparam logic [1:0] PRE_CODE_3  = 2'h1;
    localparam logic [1:0] PRE_CODE_4  = 2'h2;
    localparam logic [3:0] PRE_LAST_1  = 4'h0;
    localparam logic [3:0] PRE_LAST_3  = 4'h2;
    localparam logic [3:0] PRE_LAST_4  = 4'h3;
    localparam logic [3:0] PRE_LAST_13 = 4'hc;
    localparam logic [3:0] DIV16_LAST  = 4'hf;
    localparam logic [7:0] DIV_ONE     = 8'h01;

    typedef enum logic [0:0] {
        SEQ_IDLE  = 1'b0,
        SEQ_ARMED = 1'b1
    } ubgdr_seq_t;

    typedef struct packed {
        logic [7:0] data;
        logic       noise;
        logic       framing;
        logic       parity;
    } ubgdr_rx_t;

endpackage

// *** tb/ubgdr_line_model.sv ***
`timescale 1ns/1ps
module ubgdr_line_model #(
    parameter int FRAME = 20
) (
    input  wire logic                  mclk_i,
    input  wire logic                  arst_n_i,
    input  wire logic                  tx_load_i,
    input  wire logic [7:0]            tx_data_i,
    input  wire logic                  send_i,
    input  wire logic [7:0]            byte_i,
    output logic                       tx_shift_empty_o,
    output logic                       tx_done_o,
    output logic                       rx_valid_o,
    output ubgdr_pkg::ubgdr_rx_t       rx_word_o,
    output logic                       rx_idle_o,
    output logic      [7:0]            last_tx_o
);
    int busy;
    assign tx_shift_empty_o = (busy == 0);
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            busy       <= 0;
            tx_done_o  <= 1'b0;
            last_tx_o  <= 8'h00;
            rx_valid_o <= 1'b0;
            rx_idle_o  <= 1'b0;
            rx_word_o  <= '0;
        end else begin
            tx_done_o  <= (busy == 1);
            rx_valid_o <= send_i;
            rx_idle_o  <= rx_valid_o;
            // word lines garbled outside the valid pulse
            rx_word_o  <= send_i ? {byte_i, 3'h0} : ~rx_word_o;
            if (tx_load_i) begin
                last_tx_o <= tx_data_i;
                busy      <= FRAME;
            end else if (busy > 0) begin
                busy <= busy - 1;
            end
        end
    end
endmodule // ubgdr_line_model

// *** tb/tb.sv ***
`timescale 1ns/1ps
module tb;
    logic                 mclk_i = 1'b0;
    logic                 arst_n_i = 1'b0;
    logic [7:0]           addr_i = 8'h00;
    logic [7:0]           wdata_i = 8'h00;
    logic                 wr_i = 1'b0;
    logic                 rd_i = 1'b0;
    logic                 send = 1'b0;
    logic [7:0]           byte_v = 8'h00;
    logic [7:0]           rdata_o, tx_data_o, last_tx, d;
    logic                 tx_load_o, tx_rate_tick_o, rx_rate_tick_o, irq_o, empty, done, valid, idle;
    ubgdr_pkg::ubgdr_rx_t word;
    int                   bad_count = 0;
    int                   total_checks = 0;
    int                   n;
    int                   pre [4] = '{1, 3, 4, 13};
    logic [24:0]          rows [11] = '{{1'b0, 24'h5000c0}, {1'b0, 24'h520000}, {1'b0, 24'h540000},
        {1'b0, 24'h550000}, {1'b0, 24'h570000}, {1'b1, 24'h52d3d3}, {1'b1, 24'h531f1f}, {1'b1, 24'h54a5a5},
        {1'b1, 24'h557e7e}, {1'b1, 24'h57ffff}, {1'b1, 24'h56ff00}};
    always #12.5 mclk_i = ~mclk_i;
    ubgdr_top i_dut (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
        .rd_i(rd_i), .rdata_o(rdata_o), .tx_shift_empty_i(empty), .tx_data_o(tx_data_o), .tx_load_o(tx_load_o),
        .tx_done_i(done), .rx_valid_i(valid), .rx_word_i(word), .rx_idle_i(idle),
        .tx_rate_tick_o(tx_rate_tick_o), .rx_rate_tick_o(rx_rate_tick_o), .irq_o(irq_o));
    ubgdr_line_model i_line (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .tx_load_i(tx_load_o), .tx_data_i(tx_data_o),
        .send_i(send), .byte_i(byte_v), .tx_shift_empty_o(empty), .tx_done_o(done), .rx_valid_o(valid),
        .rx_word_o(word), .rx_idle_o(idle), .last_tx_o(last_tx));
    task test_done;
        $display("checks %0d errors %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task chk(input logic [15:0] g, input logic [15:0] e);
        total_checks++;
        if (g !== e) begin
            bad_count++;
            $display("ERROR %0t got %h expected %h", $time, g, e);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge mclk_i);
        addr_i  <= a;
        wdata_i <= v;
        wr_i    <= 1'b1;
        @(posedge mclk_i);
        wr_i    <= 1'b0;
    endtask
    task rd(input logic [7:0] a);
        @(posedge mclk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge mclk_i);
        rd_i   <= 1'b0;
        #1 d = rdata_o;
    endtask
    task rx(input logic [7:0] b);
        @(posedge mclk_i);
        byte_v <= b;
        send   <= 1'b1;
        @(posedge mclk_i);
        send   <= 1'b0;
        repeat (4) @(posedge mclk_i);
    endtask
    // third interval only: the first two may straddle a divider change
    task per(input bit s);
        repeat (3) begin
            n = 0;
            do begin
                @(posedge mclk_i);
                n++;
            end while (!(s ? rx_rate_tick_o : tx_rate_tick_o) && n < 5000);
        end
        if (n >= 5000) begin
            bad_count++;
            $display("ERROR %0t rate tick missing", $time);
            test_done();
        end
    endtask
    initial begin
        repeat (20) @(posedge mclk_i);
        arst_n_i <= 1'b1;
        foreach (rows[i]) begin
            if (rows[i][24]) wr(rows[i][23:16], rows[i][15:8]);
            rd(rows[i][23:16]);
            chk(d, rows[i][7:0]);
        end
        wr(8'h55, 8'h00);
        wr(8'h57, 8'h00);
        for (int p = 0; p < 4; p++) begin
            wr(8'h52, {p[1:0], 6'h0a});
            per(1'b0);
            chk(n[15:0], 16'(pre[p] * 2));
            per(1'b1);
            chk(n[15:0], 16'(pre[p] * 4));
        end
        wr(8'h52, 8'h38);
        per(1'b0);
        chk(n[15:0], 16'h0080);
        wr(8'h55, 8'h05);
        per(1'b1);
        chk(n[15:0], 16'h0050);
        wr(8'h57, 8'hff);
        per(1'b0);
        chk(n[15:0], 16'h0ff0);
        wr(8'h55, 8'h00);
        per(1'b1);
        chk(n[15:0], 16'h0001);
        rd(8'h58);
        wr(8'h59, 8'h04);
        rx(8'ha5);
        chk(irq_o, 16'h0001);
        rd(8'h58);
        chk(d & 8'h04, 16'h0004);
        @(posedge mclk_i);
        chk(irq_o, 16'h0000);
        rd(8'h50);
        chk(d & 8'h20, 16'h0020);
        rd(8'h51);
        chk(d, 16'h00a5);
        rd(8'h50);
        chk(d & 8'h20, 16'h0000);
        rd(8'h51);
        rx(8'h5a);
        rd(8'h51);
        rd(8'h50);
        chk(d & 8'h20, 16'h0020);
        rd(8'h51);
        chk(d, 16'h005a);
        rd(8'h50);
        wr(8'h51, 8'h3c);
        for (n = 0; n < 50 && last_tx !== 8'h3c; n++) @(posedge mclk_i);
        chk(last_tx, 16'h003c);
        repeat (30) @(posedge mclk_i);
        rd(8'h50);
        chk(d & 8'h40, 16'h0040);
        wr(8'h51, 8'hc3);
        rd(8'h50);
        chk(d & 8'h40, 16'h0000);
        // reset in mid-run, while a frame is still on the line
        arst_n_i <= 1'b0;
        repeat (2) @(posedge mclk_i);
        arst_n_i <= 1'b1;
        rd(8'h52);
        chk(d, 16'h0000);
        rd(8'h57);
        chk(d, 16'h0000);
        test_done();
    end
endmodule // tb
